// ==== rtl/sdlc_frame_transmitter.sv ====
// SDLC frame transmitter with APB registers and bit-stuffing serialiser
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module sdlc_frame_transmitter (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        txc,
   input  wire logic        cts_n,
   output logic             txd,
   output logic             wait_n,
   output logic             ready_n,
   output logic             ext_int
);
   import sdlc_tx_pkg::*;

   ctrl_t       ctrl_q;
   cause_t      cause_q;
   kind_t       kind_q;
   logic [31:0] prdata_q;
   logic [15:0] crc_q;
   logic [7:0]  buf_q, crc_hi_q, sh_q;
   logic [3:0]  cnt_q;
   logic [2:0]  ones_q;
   logic        pready_q, pslverr_q, txd_q, wait_n_q, ready_n_q, ext_q;
   logic        eom_q, abort_q, full_q, crc2_q, frame_q, stuff_q;
   logic        txc_s1, txc_s2, txc_s3, cts_s1, cts_s2, cts_s3;

   logic        tick, cts_chg, acc, wr_fire, stall, mapped, tbe, ldnow;
   logic        shift_now, content, bit_out, take, crc_go, flag_go;
   logic [31:0] rd_word;
   logic [7:0]  ld_sh, cur_sh;
   logic [3:0]  ld_cnt, cur_cnt;
   kind_t       ld_kind, cur_kind;

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign txd     = txd_q;
   assign wait_n  = wait_n_q;
   assign ready_n = ready_n_q;
   assign ext_int = ext_q;

   // ********************************
   // Pin synchronisers
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txc_s1 <= 1'b1;
         txc_s2 <= 1'b1;
         txc_s3 <= 1'b1;
         cts_s1 <= 1'b1;
         cts_s2 <= 1'b1;
         cts_s3 <= 1'b1;
      end else begin
         txc_s1 <= txc;
         txc_s2 <= txc_s1;
         txc_s3 <= txc_s2;
         cts_s1 <= cts_n;
         cts_s2 <= cts_s1;
         cts_s3 <= cts_s2;
      end
   end

   // Data changes on the falling edge of the link clock
   assign tick    = txc_s3 & ~txc_s2;
   assign cts_chg = cts_s3 ^ cts_s2;

   // ********************************
   // APB slave
   // ********************************
   assign acc     = psel & penable;
   assign wr_fire = acc & pready_q & pwrite;
   assign mapped  = (paddr == OFS_CTRL) | (paddr == OFS_CMD) |
                    (paddr == OFS_DATA) | (paddr == OFS_STAT);
   assign stall   = psel & pwrite & (paddr == OFS_DATA) & full_q &
                    ctrl_q.wr_en & ~ctrl_q.dma;
   assign tbe     = ~full_q & (kind_q != K_CRC) & ~crc2_q;

   always_comb begin
      rd_word = '0;
      if (paddr == OFS_CTRL) rd_word[7:0] = ctrl_q;
      if (paddr == OFS_STAT) begin
         rd_word[ST_TBE] = tbe;
         rd_word[ST_EOM] = eom_q;
         rd_word[ST_EXT] = ext_q;
         rd_word[ST_CTS] = ~cts_s3;
         rd_word[ST_CAUSE +: 2] = ctrl_q.sav ? cause_q : CAUSE_NONE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else if (acc & ~pready_q & ~stall) begin
         pready_q  <= 1'b1;
         pslverr_q <= ~mapped;
         prdata_q  <= pwrite ? '0 : rd_word;
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_n_q  <= 1'b1;
         ready_n_q <= 1'b1;
      end else begin
         wait_n_q  <= ~stall;
         ready_n_q <= ~(ctrl_q.wr_en & ctrl_q.dma & ctrl_q.tx_en & ~full_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_q <= '0;
      else if (wr_fire & (paddr == OFS_CTRL)) ctrl_q <= ctrl_t'(pwdata[7:0]);
   end

   // ********************************
   // Transmit buffer
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_q  <= '0;
         full_q <= 1'b0;
      end else if (wr_fire & (paddr == OFS_DATA)) begin
         buf_q  <= pwdata[7:0];
         full_q <= 1'b1;
      end else if (ldnow & take) begin
         full_q <= 1'b0;
      end
   end

   // ********************************
   // End-of-message latch and abort
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) eom_q <= 1'b1;
      // CRC start sets the latch, winning over a clear
      else if (ldnow & crc_go) eom_q <= 1'b1;
      else if (wr_fire & (paddr == OFS_CMD) & pwdata[CMD_RST_EOM]) eom_q <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) abort_q <= 1'b0;
      else if (wr_fire & (paddr == OFS_CMD) & pwdata[CMD_ABORT]) abort_q <= 1'b1;
      else if (ldnow) abort_q <= 1'b0;
   end

   // ********************************
   // Status interrupt
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_q   <= 1'b0;
         cause_q <= CAUSE_NONE;
      end else if (ctrl_q.ext_en & ldnow & crc_go) begin
         ext_q   <= 1'b1;
         cause_q <= CAUSE_CRC;
      end else if (ctrl_q.ext_en & ldnow & flag_go) begin
         ext_q   <= 1'b1;
         cause_q <= CAUSE_FLAG;
      end else if (ctrl_q.ext_en & cts_chg) begin
         ext_q   <= 1'b1;
         cause_q <= CAUSE_CTS;
      end else if (wr_fire & (paddr == OFS_CMD) & pwdata[CMD_RST_EXT]) begin
         ext_q   <= 1'b0;
      end
   end

   // ********************************
   // Next character selection
   // ********************************
   assign ldnow = tick & (abort_q | ((cnt_q == 4'h0) & ~stuff_q));

   always_comb begin
      // flags fill the line when enabled
      ld_sh   = FLAG_PAT;
      ld_cnt  = CHAR_LEN;
      ld_kind = K_FLAG;
      take    = 1'b0;
      crc_go  = 1'b0;
      flag_go = 1'b0;
      if (abort_q) begin
         // abort replaces the character in flight
         ld_sh   = ONES_PAT;
         ld_cnt  = ABORT_LEN;
         ld_kind = K_ABORT;
      end else if (crc2_q) begin
         // flags stand in for CRC when disabled
         ld_kind = K_CRC;
         ld_sh   = ctrl_q.tx_en ? crc_hi_q : FLAG_PAT;
      end else if (!ctrl_q.tx_en) begin
         // line marks after the last character
         ld_sh   = ONES_PAT;
         ld_cnt  = MARK_LEN;
         ld_kind = K_MARK;
      end else if (full_q && (kind_q != K_MARK)) begin
         ld_sh   = buf_q;
         ld_cnt  = 4'(MIN_BITS + {2'b00, ctrl_q.bpc});
         ld_kind = K_DATA;
         take    = 1'b1;
      end else if (frame_q & ~eom_q) begin
         // CRC plus flag gives the abort window
         ld_sh   = ~crc_q[7:0];
         ld_kind = K_CRC;
         crc_go  = 1'b1;
      end else begin
         // first flag after enable, even with data buffered
         flag_go = frame_q | (kind_q == K_CRC);
      end
   end

   assign cur_sh    = ldnow ? ld_sh : sh_q;
   assign cur_cnt   = ldnow ? ld_cnt : cnt_q;
   assign cur_kind  = ldnow ? ld_kind : kind_q;
   assign shift_now = tick & (ldnow | ~stuff_q);
   assign bit_out   = cur_sh[0];
   assign content   = (cur_kind == K_DATA) |
                      ((cur_kind == K_CRC) & ctrl_q.tx_en);

   // ********************************
   // Frame tracking
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_q  <= 1'b0;
         crc2_q   <= 1'b0;
         crc_hi_q <= '0;
      end else if (ldnow) begin
         frame_q  <= take;
         crc2_q   <= crc_go;
         if (crc_go) crc_hi_q <= ~crc_q[15:8];
      end
   end

   // ********************************
   // Serialiser
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txd_q   <= 1'b1;
         sh_q    <= ONES_PAT;
         cnt_q   <= 4'h0;
         kind_q  <= K_MARK;
         ones_q  <= 3'h0;
         stuff_q <= 1'b0;
      end else if (shift_now) begin
         txd_q   <= bit_out;
         sh_q    <= cur_sh >> 1;
         cnt_q   <= 4'(cur_cnt - 4'h1);
         kind_q  <= cur_kind;
         // stuff a zero after five ones of content
         ones_q  <= (content & bit_out) ? 3'(ones_q + 3'h1) : 3'h0;
         stuff_q <= content & bit_out & (ones_q == 3'(STUFF_RUN - 3'h1));
      end else if (tick) begin
         txd_q   <= 1'b0;
         ones_q  <= 3'h0;
         stuff_q <= 1'b0;
      end
   end

   // ********************************
   // CRC generator
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_q <= CRC_INIT;
      end else if (wr_fire & (paddr == OFS_CMD) & pwdata[CMD_RST_CRC]) begin
         crc_q <= CRC_INIT;
      end else if (shift_now & (cur_kind == K_DATA) & ctrl_q.crc_en) begin
         // gated by the CRC enable bit
         crc_q <= (crc_q >> 1) ^ ((crc_q[0] ^ bit_out) ? CRC_POLY : 16'h0000);
      end
   end

   // ********************************
   // Assertions
   // ********************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_wait_stretch: assert property (
      stall |=> (!wait_n_q && !pready_q))
      else $error("write not stretched while buffer full");

   chk_dma_ready: assert property (
      (ctrl_q.dma && ctrl_q.wr_en && ctrl_q.tx_en && !full_q) |=> !ready_n_q)
      else $error("ready not given with empty buffer");

   chk_crc_underrun: assert property (
      (ldnow && !abort_q && !crc2_q && ctrl_q.tx_en && !full_q && frame_q && !eom_q)
      |=> (kind_q == K_CRC && crc2_q))
      else $error("underrun did not start CRC");

   chk_eom_no_crc: assert property (
      (ldnow && eom_q && !crc2_q && !full_q) |=> kind_q != K_CRC)
      else $error("CRC sent with latch set");

   chk_crc_sets_eom: assert property (
      (ldnow && crc_go) |=> (eom_q && !tbe))
      else $error("CRC start did not set latch");

   chk_crc_done_tbe: assert property (
      (ldnow && kind_q == K_CRC && !crc2_q && ld_kind == K_FLAG && !full_q)
      |=> tbe)
      else $error("buffer empty not set after CRC");

   chk_underrun_irq: assert property (
      (ldnow && crc_go && ctrl_q.ext_en) |=> ##[0:1] ext_q)
      else $error("no status interrupt on underrun");

   chk_abort_start: assert property (
      (wr_fire && paddr == OFS_CMD && pwdata[CMD_ABORT])
      |-> ##[1:40] (kind_q == K_ABORT))
      else $error("abort not started");

   chk_abort_ones: assert property (
      (ldnow && abort_q) |=> (txd_q && cnt_q == 4'h7 && !stuff_q))
      else $error("abort not sent as ones");

   chk_mark_off: assert property (
      (ldnow && !abort_q && !crc2_q && !ctrl_q.tx_en) |=> (txd_q && kind_q == K_MARK))
      else $error("line not marking while disabled");

   chk_char_len: assert property (
      (ldnow && take) |=> cnt_q == 4'(MIN_BITS + {2'b00, $past(ctrl_q.bpc)} - 4'h1))
      else $error("character length wrong");

   chk_stuff_zero: assert property (
      stuff_q |-> (ones_q == STUFF_RUN))
      else $error("zero inserted at wrong run length");

   cov_abort: cover property (ldnow && abort_q);
   cov_crc_start: cover property (ldnow && crc_go);
   cov_stall: cover property (stall ##1 !stall);
   cov_stuff: cover property (stuff_q && tick);

endmodule : sdlc_frame_transmitter

// ==== inc/sdlc_tx_pkg.sv ====
// Constants, field layouts and types of the SDLC frame transmitter
package sdlc_tx_pkg;
   // ********************************
   // Register byte addresses
   // ********************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD  = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   // ********************************
   // Command and status bit positions
   // ********************************
   localparam int CMD_RST_EOM = 0;
   localparam int CMD_ABORT   = 1;
   localparam int CMD_RST_CRC = 2;
   localparam int CMD_RST_EXT = 3;
   localparam int ST_TBE      = 0;
   localparam int ST_EOM      = 1;
   localparam int ST_EXT      = 2;
   localparam int ST_CTS      = 3;
   localparam int ST_CAUSE    = 4;
   // ********************************
   // Line patterns and counts
   // ********************************
   localparam logic [7:0]  FLAG_PAT  = 8'h7E;
   localparam logic [7:0]  ONES_PAT  = 8'hFF;
   localparam logic [3:0]  CHAR_LEN  = 4'h8;
   localparam logic [3:0]  ABORT_LEN = 4'h8;
   localparam logic [3:0]  MARK_LEN  = 4'h1;
   localparam logic [3:0]  MIN_BITS  = 4'h5;
   localparam logic [2:0]  STUFF_RUN = 3'h5;
   localparam logic [15:0] CRC_INIT  = 16'hFFFF;
   localparam logic [15:0] CRC_POLY  = 16'h8408;
   // ********************************
   // Types
   // ********************************
   typedef struct packed {
      logic       sav;
      logic       ext_en;
      logic       dma;
      logic       wr_en;
      logic       tx_en;
      logic [1:0] bpc;
      logic       crc_en;
   } ctrl_t;
   typedef enum logic [4:0] {
      K_MARK  = 5'b00001,
      K_FLAG  = 5'b00010,
      K_DATA  = 5'b00100,
      K_CRC   = 5'b01000,
      K_ABORT = 5'b10000
   } kind_t;
   typedef enum logic [1:0] {
      CAUSE_NONE = 2'h0,
      CAUSE_CRC  = 2'h1,
      CAUSE_FLAG = 2'h2,
      CAUSE_CTS  = 2'h3
   } cause_t;
endpackage : sdlc_tx_pkg

// ==== tb/sdlc_line_monitor.sv ====
// Remote SDLC receiving station: makes the bit clock and decodes the line
`timescale 1ns/1ps
module sdlc_line_monitor (
   output logic        txc,
   input  wire logic   txd,
   output int          flags,
   output int          frames,
   output int          aborts,
   output int          last_bits,
   output int          last_run,
   output logic [15:0] last_crc,
   output logic [7:0]  first_byte
);
   logic bitbuf [0:511];
   int   nbits;
   int   ones;
   logic in_frame;

   // Free running bit clock, phase unrelated to pclk
   initial begin
      {flags, frames, aborts, last_bits, last_run, nbits, ones} = '0;
      in_frame = 1'b0;
      last_crc = 16'h0000;
      first_byte = 8'h00;
      txc = 1'b1;
      #7;
      forever #40 txc = ~txc;
   end

   // Sample just before the next launch; frame bits exclude the closing flag
   always @(negedge txc) begin
      if (txd === 1'b1) begin
         ones = ones + 1;
         if (ones == 7) begin
            aborts = aborts + 1;
            in_frame = 1'b0;
         end
         if (in_frame && nbits < 512) begin
            bitbuf[nbits] = 1'b1;
            nbits = nbits + 1;
         end
      end else begin
         if (ones >= 7)
            last_run = ones;
         if (ones == 6) begin
            flags = flags + 1;
            if (in_frame && nbits > 7) begin
               last_bits = nbits - 7;
               last_crc = 16'hFFFF;
               for (int i = 0; i < last_bits; i++)
                  last_crc = (last_crc >> 1) ^ ((last_crc[0] ^ bitbuf[i]) ? 16'h8408 : 16'h0);
               for (int i = 0; i < 8; i++)
                  first_byte[i] = bitbuf[i];
               frames = frames + 1;
            end
            in_frame = 1'b1;
            nbits = 0;
         end else if (ones != 5 && in_frame && nbits < 512) begin
            bitbuf[nbits] = 1'b0;
            nbits = nbits + 1;
         end
         ones = 0;
      end
   end
endmodule : sdlc_line_monitor

// ==== tb/tb.sv ====
// Self-checking testbench of the SDLC frame transmitter
`timescale 1ns/1ps
module tb;
   import sdlc_tx_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, txc, cts_n = 1'b1, txd, wait_n, ready_n, ext_int, err, saw_wait = 1'b0;
   logic [15:0] last_crc;
   logic [7:0] first_byte;
   int flags, frames, aborts, last_bits, last_run, failures = 0, checks_done = 0, f0, a0, k;

   always #5 pclk = ~pclk;
   always @(posedge pclk) if (wait_n === 1'b0) saw_wait <= 1'b1;

   sdlc_frame_transmitter sdlc_frame_transmitter_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .txc(txc), .cts_n(cts_n),
      .txd(txd), .wait_n(wait_n), .ready_n(ready_n), .ext_int(ext_int));
   sdlc_line_monitor sdlc_line_monitor_inst (.txc(txc), .txd(txd), .flags(flags),
      .frames(frames), .aborts(aborts), .last_bits(last_bits), .last_run(last_run),
      .last_crc(last_crc), .first_byte(first_byte));

   // ********************************
   // Tasks
   // ********************************
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 5000);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 5000) begin
         failures++;
         summarize();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h0);
      check(q, exp, "read data");
      check({31'h0, err}, {31'h0, exp_err}, "slave error");
   endtask : rd

   task automatic ticks(input int n);
      repeat (n) @(posedge pclk);
   endtask : ticks

   task automatic wait_frame(input int n);
      int k;
      for (k = 0; k < 20000 && frames < n; k++)
         @(posedge pclk);
      check(frames, n, "frame count");
      if (frames < n) summarize();
   endtask : wait_frame

   // ********************************
   // Scenarios
   // ********************************
   initial begin
      ticks(3);
      presetn <= 1'b1;
      @(posedge pclk);
      check({txd, wait_n, ready_n, ext_int, pready}, 5'b11100, "reset outputs");
      rd(OFS_STAT, 32'h3, 1'b0);
      rd(OFS_CTRL, 32'h0, 1'b0);
      rd(OFS_CMD, 32'h0, 1'b0);
      rd(8'h10, 32'h0, 1'b1);
      ticks(300);
      check(txd, 1'b1, "marking while disabled");
      wr(OFS_CTRL, 32'h5F);
      wr(OFS_CMD, 32'h4);
      ticks(400);
      check(flags > 0, 1'b1, "idle flags");
      rd(OFS_CTRL, 32'h5F, 1'b0);
      wr(OFS_DATA, 32'hA5);
      wr(OFS_CMD, 32'h1);
      wr(OFS_DATA, 32'hFF);
      wr(OFS_DATA, 32'h7E);
      check(saw_wait, 1'b1, "write stretched");
      wait_frame(1);
      check(last_bits, 40, "frame bits");
      check(last_crc, 16'hF0B8, "frame check");
      check(first_byte, 8'hA5, "address first");
      ticks(100);
      check(ext_int, 1'b1, "status interrupt");
      rd(OFS_STAT, 32'h7, 1'b0);
      wr(OFS_CMD, 32'h8);
      ticks(2);
      check(ext_int, 1'b0, "interrupt cleared");
      wr(OFS_CMD, 32'h4);
      wr(OFS_DATA, 32'h3C);
      wr(OFS_CMD, 32'h1);
      wr(OFS_DATA, 32'h15);
      wr(OFS_CTRL, 32'h59);
      wait_frame(2);
      check(last_bits, 29, "length at load");
      check(last_crc, 16'hF0B8, "covers all chars");
      wr(OFS_CTRL, 32'h5F);
      a0 = aborts;
      wr(OFS_CMD, 32'h4);
      wr(OFS_DATA, 32'h11);
      wr(OFS_CMD, 32'h1);
      wr(OFS_DATA, 32'h22);
      wr(OFS_DATA, 32'h32);
      wr(OFS_CMD, 32'h2);
      ticks(1500);
      check(aborts, a0 + 1, "abort seen");
      check(last_run >= 8 && last_run < 14, 1'b1, "abort length");
      check(frames, 2, "no false frame");
      wr(OFS_CMD, 32'h8);
      wr(OFS_CMD, 32'h4);
      wr(OFS_DATA, 32'h11);
      wr(OFS_CMD, 32'h1);
      for (k = 0; k < 2000 && ext_int !== 1'b1; k++)
         @(posedge pclk);
      check(ext_int, 1'b1, "underrun started");
      if (ext_int !== 1'b1) summarize();
      wr(OFS_CMD, 32'h2);
      ticks(600);
      check(frames, 2, "abort inside window");
      check(aborts, a0 + 2, "abort after underrun");
      wr(OFS_CMD, 32'h4);
      wr(OFS_DATA, 32'h55);
      wr(OFS_CMD, 32'h1);
      wr(OFS_DATA, 32'h66);
      wr(OFS_CTRL, 32'h57);
      ticks(300);
      repeat (8) begin
         check(txd, 1'b1, "marking after disable");
         ticks(25);
      end
      check(frames, 2, "no closing after disable");
      f0 = flags;
      wr(OFS_CTRL, 32'h5F);
      ticks(2000);
      check(flags > f0, 1'b1, "flag after enable");
      check(frames, 3, "frame opened after enable");
      check(first_byte, 8'h66, "buffered byte kept");
      wr(OFS_CTRL, 32'hDF);
      wr(OFS_CMD, 32'h8);
      cts_n <= 1'b0;
      ticks(20);
      check(ext_int, 1'b1, "clear-to-send change");
      rd(OFS_STAT, 32'h3F, 1'b0);
      wr(OFS_CTRL, 32'h7F);
      ticks(5);
      check(ready_n, 1'b0, "dma ready");
      summarize();
   end
endmodule : tb
